// [src/tc_regs.vh]
// Register map, field positions and constants of the dual timer.
// Assumes an 8-bit register port with byte addresses.
`ifndef TC_REGS_VH
`define TC_REGS_VH
// Register addresses
`define TC_A_CTRL   8'h88
`define TC_A_MODE   8'h89
`define TC_A_TLA    8'h8A
`define TC_A_TLB    8'h8B
`define TC_A_THA    8'h8C
`define TC_A_THB    8'h8D
`define TC_A_PRE    8'h8E
`define TC_A_IEN    8'hA8
`define TC_A_IPR    8'hB8
`define TC_A_STS    8'h90
`define TC_A_MSK    8'h91
// Run and flag register fields
`define TC_B_TFB    7
`define TC_B_RUNB   6
`define TC_B_TFA    5
`define TC_B_RUNA   4
`define TC_B_EXB    3
`define TC_B_EXA    1
// Mode register fields
`define TC_F_MODEA  1:0
`define TC_B_SRCA   2
`define TC_F_MODEB  5:4
`define TC_B_SRCB   6
// Prescale, enable and priority fields
`define TC_B_PREA   0
`define TC_B_PREB   1
`define TC_B_PREC   2
`define TC_B_GIE    7
`define TC_B_IEB    3
`define TC_B_IEA    1
`define TC_B_IPB    3
`define TC_B_IPA    1
// Mode codes
`define TC_M_13     2'h0
`define TC_M_16     2'h1
`define TC_M_RELOAD 2'h2
`define TC_M_SPLIT  2'h3
// Divide-by-twelve prescaler, last count
`define TC_DIV_LAST 4'hB
// Reset values
`define TC_RST8     8'h00
`define TC_RST4     4'h0
`define TC_RST3     3'h0
`define TC_RST2     2'h0
// Writable bits of mode, enable and priority registers
`define TC_MASK_MODE 8'h77
`define TC_MASK_IEN  8'hEF
`define TC_MASK_IPR  8'h6F
// Prescale field and two-bit status or mask field
`define TC_F_PRE    2:0
`define TC_F_FLAGS  1:0
`endif

// [src/tc_edge.v]
// Count pin synchroniser and falling edge detector.
// Assumes the pin is asynchronous to core_clk.
`timescale 1ns/1ps
module tc_edge (
   // Clock and reset
   input  wire core_clk,
   input  wire rst,
   // Pin and event
   input  wire pin,
   output reg  fall
);
   reg sync_1;   // First stage, read by sync_2 only
   reg sync_2;   // Second stage
   reg last;     // Previous settled level

   // Two-stage crossing then high-to-low detection
   always @(posedge core_clk) begin
      if (rst) begin
         sync_1 <= 1'b1;
         sync_2 <= 1'b1;
         last   <= 1'b1;
         fall   <= 1'b0;
      end else begin
         sync_1 <= pin;
         sync_2 <= sync_1;
         last   <= sync_2;
         fall   <= last & ~sync_2;
      end
   end
endmodule // tc_edge

// [src/tc_timer.v]
// Two 16-bit timer/counters with run, mode, prescale and interrupt
// controls. Assumes an 8-bit register port on core_clk and vector
// acknowledge pulses from the processor core on the same clock.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "tc_regs.vh"

////////////////////////////////////////////////////////////////////
// What this block does
// - Overflow sets flag; vectoring clears it
// - Run bit starts or stops each timer
// - Source bit picks clock or pin
// - Timer B modes: 13, 16, reload
// - Timer B mode three holds count
// - Timer A modes: 13 and 16 bit
// - Timer A reload copies high into low
// - Timer A split: two 8-bit timers
// - Mode register fields, bits 3,7 reserved
// - No counting without run bit
// - Prescale bit: divide by twelve or one
// - Priority bits three and one
// - Enabled flag raises interrupt request
// - Starting keeps count; software preloads
// - Pin falling edge adds one
// - Split high byte overflow uses timer B
module tc_timer (
   // Clock and reset
   input  wire       core_clk,
   input  wire       rst,
   // Register port
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr,
   input  wire       rd,
   output reg  [7:0] rdata,
   // External count pins
   input  wire       timer_a_count_pin,
   input  wire       timer_b_count_pin,
   // Vector acknowledge from the core
   input  wire       vector_a,
   input  wire       vector_b,
   // Interrupt requests and priorities
   output reg        irq_req_a,
   output reg        irq_req_b,
   output reg        irq_prio_a,
   output reg        irq_prio_b,
   output reg        irq
);

   ////////////////////////////////////////////////////////////////
   // One count step for a timer, returns {overflow, high, low}
   function [16:0] tc_step;
      input [1:0] mode;
      input [7:0] hi;
      input [7:0] lo;
      begin
         tc_step = {1'b0, hi, lo};
         case (mode)
            // Five low bits carry into the high byte
            `TC_M_13: begin
               if (lo[4:0] == 5'h1F)
                  tc_step = {hi == 8'hFF, hi + 8'h01, lo[7:5], 5'h00};
               else
                  tc_step = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
            end
            // Full sixteen bits
            `TC_M_16: begin
               tc_step = {{hi, lo} == 16'hFFFF, {hi, lo} + 16'h0001};
            end
            // Low byte reloads from the high byte
            `TC_M_RELOAD: begin
               if (lo == 8'hFF)
                  tc_step = {1'b1, hi, hi};
               else
                  tc_step = {1'b0, hi, lo + 8'h01};
            end
            // Low byte alone, high byte left to its own path
            `TC_M_SPLIT: begin
               tc_step = {lo == 8'hFF, hi, lo + 8'h01};
            end
            default: tc_step = {1'b0, hi, lo};
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // Registers
   reg [7:0] tl_a;        // Timer A count low
   reg [7:0] th_a;        // Timer A count high
   reg [7:0] tl_b;        // Timer B count low
   reg [7:0] th_b;        // Timer B count high
   reg       tf_a;        // Timer A overflow flag
   reg       tf_b;        // Timer B overflow flag
   reg       run_a;       // Timer A run
   reg       run_b;       // Timer B run
   reg       ext_a;       // Edge flag A, storage only
   reg       ext_b;       // Edge flag B, storage only
   reg [7:0] mode_r;      // Mode select
   reg [2:0] pre_r;       // Prescale select
   reg [7:0] ien_r;       // Interrupt enables
   reg [7:0] ipr_r;       // Interrupt priorities
   reg [1:0] sts_r;       // Sticky overflow status
   reg [1:0] msk_r;       // Status mask
   reg [3:0] div_cnt;     // Divide-by-twelve counter
   reg       div_tick;    // One pulse per twelve cycles

   ////////////////////////////////////////////////////////////////
   // Synchronised pin edges
   wire [1:0] pins;       // Pins as a vector
   wire [1:0] fall;       // Falling edge pulses

   assign pins = {timer_b_count_pin, timer_a_count_pin};

   // One synchroniser per count pin
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
         tc_edge u_edge (
            .core_clk (core_clk),
            .rst      (rst),
            .pin      (pins[gi]),
            .fall     (fall[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // Field decode
   wire [1:0] mode_a;     // Timer A mode
   wire [1:0] mode_b;     // Timer B mode
   wire       src_a;      // Timer A counts pin
   wire       src_b;      // Timer B counts pin
   wire       split;      // Timer A in split mode

   assign mode_a = mode_r[`TC_F_MODEA];
   assign mode_b = mode_r[`TC_F_MODEB];
   assign src_a  = mode_r[`TC_B_SRCA];
   assign src_b  = mode_r[`TC_B_SRCB];
   assign split  = (mode_a == `TC_M_SPLIT);

   ////////////////////////////////////////////////////////////////
   // Tick selection
   wire tmr_a;            // Internal tick at A's rate
   wire tmr_b;            // Internal tick at B's rate
   wire tick_a;           // Timer A input tick
   wire tick_b;           // Timer B input tick

   // Prescale bit picks undivided or divided clock
   assign tmr_a  = pre_r[`TC_B_PREA] | div_tick;
   assign tmr_b  = pre_r[`TC_B_PREB] | div_tick;
   // Source bit picks pin edges or internal ticks
   assign tick_a = src_a ? fall[0] : tmr_a;
   assign tick_b = src_b ? fall[1] : tmr_b;

   ////////////////////////////////////////////////////////////////
   // Advance conditions and overflow events
   wire        adv_a;     // Timer A steps
   wire        adv_h;     // Split high byte steps
   wire        adv_b;     // Timer B steps
   wire [16:0] st_a;      // Timer A next state
   wire [16:0] st_b;      // Timer B next state
   wire        ev_a;      // Timer A overflow event
   wire        ev_b;      // Timer B or split high overflow

   // Nothing counts while its run bit is low
   assign adv_a = run_a & tick_a;
   // Split high byte is a timer only, on timer B's run bit
   assign adv_h = split & run_b & tmr_a;
   // Timer B halts in its mode three or while A is split
   assign adv_b = run_b & tick_b & ~split & (mode_b != `TC_M_SPLIT);

   assign st_a = tc_step(mode_a, th_a, tl_a);
   assign st_b = tc_step(mode_b, th_b, tl_b);

   assign ev_a = adv_a & st_a[16];
   assign ev_b = (adv_b & st_b[16]) | (adv_h & (th_a == 8'hFF));

   ////////////////////////////////////////////////////////////////
   // Write decode
   wire w_ctrl;           // Run and flag register write
   wire w_tla;            // Timer A low write
   wire w_tha;            // Timer A high write
   wire w_tlb;            // Timer B low write
   wire w_thb;            // Timer B high write

   assign w_ctrl = wr & (addr == `TC_A_CTRL);
   assign w_tla  = wr & (addr == `TC_A_TLA);
   assign w_tha  = wr & (addr == `TC_A_THA);
   assign w_tlb  = wr & (addr == `TC_A_TLB);
   assign w_thb  = wr & (addr == `TC_A_THB);

   ////////////////////////////////////////////////////////////////
   // Divide-by-twelve prescaler, free running
   always @(posedge core_clk) begin
      if (rst) begin
         div_cnt  <= `TC_RST4;
         div_tick <= 1'b0;
      end else begin
         // Wrap after the last count
         if (div_cnt == `TC_DIV_LAST) begin
            div_cnt  <= `TC_RST4;
            div_tick <= 1'b1;
         end else begin
            div_cnt  <= div_cnt + 4'h1;
            div_tick <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Timer A count; a write wins over a step
   always @(posedge core_clk) begin
      if (rst) begin
         tl_a <= `TC_RST8;
         th_a <= `TC_RST8;
      end else begin
         // Low byte: software load, else step
         if (w_tla)
            tl_a <= wdata;
         else if (adv_a)
            tl_a <= st_a[7:0];
         // High byte: load, split step, or carry
         if (w_tha)
            th_a <= wdata;
         else if (adv_h)
            th_a <= th_a + 8'h01;
         else if (adv_a)
            th_a <= st_a[15:8];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Timer B count; held when not advancing
   always @(posedge core_clk) begin
      if (rst) begin
         tl_b <= `TC_RST8;
         th_b <= `TC_RST8;
      end else begin
         // Low byte
         if (w_tlb)
            tl_b <= wdata;
         else if (adv_b)
            tl_b <= st_b[7:0];
         // High byte
         if (w_thb)
            th_b <= wdata;
         else if (adv_b)
            th_b <= st_b[15:8];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Run and flag register; a set wins over any clear
   always @(posedge core_clk) begin
      if (rst) begin
         tf_a  <= 1'b0;
         tf_b  <= 1'b0;
         run_a <= 1'b0;
         run_b <= 1'b0;
         ext_a <= 1'b0;
         ext_b <= 1'b0;
      end else begin
         // Run bits never touch the count
         if (w_ctrl) begin
            run_a <= wdata[`TC_B_RUNA];
            run_b <= wdata[`TC_B_RUNB];
            ext_a <= wdata[`TC_B_EXA];
            ext_b <= wdata[`TC_B_EXB];
         end
         // Overflow sets, vectoring clears, a write loads the written bit
         if (ev_a)
            tf_a <= 1'b1;
         else if (w_ctrl)
            tf_a <= wdata[`TC_B_TFA];
         else if (vector_a)
            tf_a <= 1'b0;
         // Same for timer B, fed also by split high byte
         if (ev_b)
            tf_b <= 1'b1;
         else if (w_ctrl)
            tf_b <= wdata[`TC_B_TFB];
         else if (vector_b)
            tf_b <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Configuration registers
   always @(posedge core_clk) begin
      if (rst) begin
         mode_r <= `TC_RST8;
         pre_r  <= `TC_RST3;
         ien_r  <= `TC_RST8;
         ipr_r  <= `TC_RST8;
         msk_r  <= `TC_RST2;
      end else if (wr) begin
         case (addr)
            // Bits 3 and 7 stay zero
            `TC_A_MODE: mode_r <= wdata & `TC_MASK_MODE;
            `TC_A_PRE:  pre_r  <= wdata[`TC_F_PRE];
            `TC_A_IEN:  ien_r  <= wdata & `TC_MASK_IEN;
            `TC_A_IPR:  ipr_r  <= wdata & `TC_MASK_IPR;
            `TC_A_MSK:  msk_r  <= wdata[`TC_F_FLAGS];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Sticky status, write one to clear; an event wins
   always @(posedge core_clk) begin
      if (rst) begin
         sts_r <= `TC_RST2;
      end else begin
         if (wr && (addr == `TC_A_STS))
            sts_r <= (sts_r & ~wdata[`TC_F_FLAGS]) | {ev_b, ev_a};
         else
            sts_r <= sts_r | {ev_b, ev_a};
      end
   end

   ////////////////////////////////////////////////////////////////
   // Interrupt outputs, all registered
   always @(posedge core_clk) begin
      if (rst) begin
         irq_req_a  <= 1'b0;
         irq_req_b  <= 1'b0;
         irq_prio_a <= 1'b0;
         irq_prio_b <= 1'b0;
         irq        <= 1'b0;
      end else begin
         // Flag and enables form the request
         irq_req_a  <= tf_a & ien_r[`TC_B_IEA] & ien_r[`TC_B_GIE];
         irq_req_b  <= tf_b & ien_r[`TC_B_IEB] & ien_r[`TC_B_GIE];
         // Priority level follows the priority register
         irq_prio_a <= ipr_r[`TC_B_IPA];
         irq_prio_b <= ipr_r[`TC_B_IPB];
         // Any unmasked sticky bit
         irq        <= |(sts_r & msk_r);
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe; unmapped reads zero
   always @(posedge core_clk) begin
      if (rst || !rd) begin
         rdata <= `TC_RST8;
      end else begin
         case (addr)
            `TC_A_CTRL: rdata <= {tf_b, run_b, tf_a, run_a, ext_b, 1'b0, ext_a, 1'b0};
            `TC_A_MODE: rdata <= mode_r;
            `TC_A_TLA:  rdata <= tl_a;
            `TC_A_TLB:  rdata <= tl_b;
            `TC_A_THA:  rdata <= th_a;
            `TC_A_THB:  rdata <= th_b;
            `TC_A_PRE:  rdata <= {5'h00, pre_r};
            `TC_A_IEN:  rdata <= ien_r;
            `TC_A_IPR:  rdata <= ipr_r;
            `TC_A_STS:  rdata <= {6'h00, sts_r};
            `TC_A_MSK:  rdata <= {6'h00, msk_r};
            default:    rdata <= `TC_RST8;
         endcase
      end
   end

endmodule // tc_timer

// [test/tc_pin_src.sv]
// Model of the pulse sources that drive the two count pins.
// Assumes go requests are one-cycle pulses on core_clk.
`timescale 1ns/1ps
module tc_pin_src (
   // Clock and reset
   input  wire core_clk,
   input  wire rst,
   // Pulse requests
   input  wire go_a,
   input  wire go_b,
   // Count pins, idle high
   output wire pin_a,
   output wire pin_b
);
   reg [2:0] low_a = 3'h0; // Cycles left low on pin A
   reg [2:0] low_b = 3'h0; // Cycles left low on pin B
   ////////////////////////////////////////////////////////////////
   // Each request pulls its pin low for six cycles: one falling edge
   always @(posedge core_clk) begin
      low_a <= rst ? 3'h0 : go_a ? 3'h6 : (low_a != 3'h0) ? low_a - 3'h1 : 3'h0;
      low_b <= rst ? 3'h0 : go_b ? 3'h6 : (low_b != 3'h0) ? low_b - 3'h1 : 3'h0;
   end
   // Pins rest high between pulses
   assign pin_a = (low_a == 3'h0);
   assign pin_b = (low_b == 3'h0);
endmodule // tc_pin_src

// [test/tc_timer_sva.sv]
// Checker of the dual timer register port and interrupt outputs.
// Assumes it is bound to tc_timer and sees only its ports.
`timescale 1ns/1ps
`include "tc_regs.vh"
module tc_timer_sva (
   // Clock and reset
   input wire       core_clk,
   input wire       rst,
   // Register port
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire       wr,
   input wire       rd,
   input wire [7:0] rdata,
   // Interrupt outputs
   input wire       irq_req_a,
   input wire       irq_req_b,
   input wire       irq_prio_a,
   input wire       irq_prio_b,
   input wire       irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////
   // Mode write, a quiet cycle, then its read back
   sequence s_mode_wr;
      wr && addr == `TC_A_MODE;
   endsequence
   sequence s_mode_rd;
      rd && addr == `TC_A_MODE;
   endsequence
   chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data not zero outside a read");
   chk_ctrl_reserved: assert property (rd && addr == `TC_A_CTRL |=> rdata[2] == 1'b0 && rdata[0] == 1'b0)
      else $error("control reserved bits not zero");
   chk_mode_readback: assert property (s_mode_wr ##1 !wr ##1 s_mode_rd |=> rdata == ($past(wdata, 3) & 8'h77))
      else $error("mode read back wrong");
   chk_prio_reserved: assert property (rd && addr == `TC_A_IPR |=> (rdata & 8'h90) == 8'h00)
      else $error("priority reserved bits not zero");
   chk_prio_a_copy: assert property (wr && addr == `TC_A_IPR |-> ##2 irq_prio_a == $past(wdata[1], 2))
      else $error("priority A output wrong");
   chk_prio_b_copy: assert property (wr && addr == `TC_A_IPR |-> ##2 irq_prio_b == $past(wdata[3], 2))
      else $error("priority B output wrong");
   chk_req_a_off: assert property (wr && addr == `TC_A_IEN && !(wdata[1] && wdata[7]) |-> ##2 !irq_req_a)
      else $error("request A while disabled");
   chk_req_b_off: assert property (wr && addr == `TC_A_IEN && !(wdata[3] && wdata[7]) |-> ##2 !irq_req_b)
      else $error("request B while disabled");
   chk_irq_masked: assert property (wr && addr == `TC_A_MSK && wdata[1:0] == 2'h0 |-> ##2 !irq)
      else $error("interrupt while masked");
endmodule // tc_timer_sva
bind tc_timer tc_timer_sva tc_timer_sva_i (.core_clk(core_clk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq_req_a(irq_req_a),
   .irq_req_b(irq_req_b), .irq_prio_a(irq_prio_a), .irq_prio_b(irq_prio_b), .irq(irq));

// [test/test_dual_timer_counter_control.sv]
// Self-checking bench of the dual timer: registers, counting, interrupts.
// Assumes tc_timer, tc_pin_src and the bound checker are compiled with it.
`timescale 1ns/1ps
`include "tc_regs.vh"
module test_dual_timer_counter_control;
   reg        core_clk = 1'b0; // 200 MHz clock
   reg        rst      = 1'b1; // Synchronous reset
   reg  [7:0] addr     = 8'h00; // Register address
   reg  [7:0] wdata    = 8'h00; // Write data
   reg        wr       = 1'b0; // Write strobe
   reg        rd       = 1'b0; // Read strobe
   reg        vector_a = 1'b0; // Vector acknowledge A
   reg        vector_b = 1'b0; // Vector acknowledge B
   reg        go_a     = 1'b0; // Pulse request pin A
   reg        go_b     = 1'b0; // Pulse request pin B
   wire [7:0] rdata;
   wire       pin_a, pin_b, irq_req_a, irq_req_b, irq_prio_a, irq_prio_b, irq;
   integer    errors   = 0;
   integer    n_checks = 0;
   integer    cycles   = 0;
   integer    i;
   // All mapped registers, for the reset sweep
   localparam [87:0] ALL = {`TC_A_CTRL, `TC_A_MODE, `TC_A_TLA, `TC_A_TLB, `TC_A_THA,
      `TC_A_THB, `TC_A_PRE, `TC_A_IEN, `TC_A_IPR, `TC_A_STS, `TC_A_MSK};
   tc_timer tc_timer_i (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .timer_a_count_pin(pin_a), .timer_b_count_pin(pin_b),
      .vector_a(vector_a), .vector_b(vector_b), .irq_req_a(irq_req_a), .irq_req_b(irq_req_b),
      .irq_prio_a(irq_prio_a), .irq_prio_b(irq_prio_b), .irq(irq));
   tc_pin_src tc_pin_src_i (.core_clk(core_clk), .rst(rst), .go_a(go_a), .go_b(go_b),
      .pin_a(pin_a), .pin_b(pin_b));
   initial forever #2.5 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////
   // Verdict and the hang guard
   task print_verdict;
      begin
         $display("Checks %0d, errors %0d", n_checks, errors);
         if (errors == 0 && n_checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         print_verdict;
      end
   end
   // Compare and count
   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // One write, then a quiet cycle so the strobe never toggles twice at once
   task wr_reg(input [7:0] a, input [7:0] d);
      begin
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge core_clk);
         wr <= 1'b0;
         @(posedge core_clk);
      end
   endtask
   // One read; data stand in the following cycle only
   task rd_chk(input [7:0] a, input [7:0] exp);
      begin
         addr <= a;
         rd <= 1'b1;
         @(posedge core_clk);
         rd <= 1'b0;
         #1;
         chk(rdata, exp);
         @(posedge core_clk);
      end
   endtask
   // Run for exactly one undivided tick: start, then stop at the next edge
   task one_step(input [7:0] run);
      begin
         addr <= `TC_A_CTRL;
         wdata <= run;
         wr <= 1'b1;
         @(posedge core_clk);
         wdata <= 8'h00;
         @(posedge core_clk);
         wr <= 1'b0;
         @(posedge core_clk);
      end
   endtask
   // Load both counts, take one tick, compare, then clear flags by vectoring
   task step_case(input [7:0] mode, input [15:0] a, input [15:0] b, input [7:0] run,
                  input [7:0] ectl, input [15:0] ea, input [15:0] eb);
      begin
         wr_reg(`TC_A_PRE, 8'h03);
         wr_reg(`TC_A_MODE, mode);
         wr_reg(`TC_A_THA, a[15:8]);
         wr_reg(`TC_A_TLA, a[7:0]);
         wr_reg(`TC_A_THB, b[15:8]);
         wr_reg(`TC_A_TLB, b[7:0]);
         one_step(run);
         rd_chk(`TC_A_CTRL, ectl);
         rd_chk(`TC_A_THA, ea[15:8]);
         rd_chk(`TC_A_TLA, ea[7:0]);
         rd_chk(`TC_A_THB, eb[15:8]);
         rd_chk(`TC_A_TLB, eb[7:0]);
         chk({7'h00, irq}, 8'h00);
         vector_a <= 1'b1;
         vector_b <= 1'b1;
         @(posedge core_clk);
         vector_a <= 1'b0;
         vector_b <= 1'b0;
         @(posedge core_clk);
         rd_chk(`TC_A_CTRL, 8'h00);
      end
   endtask
   ////////////////////////////////////////////////////////////////
   // Reset values, reserved bits, unmapped place, priority outputs
   task t_regs;
      begin
         for (i = 0; i < 11; i = i + 1)
            rd_chk(ALL[i * 8 +: 8], 8'h00);
         wr_reg(`TC_A_MODE, 8'hFF);
         rd_chk(`TC_A_MODE, 8'h77);
         wr_reg(`TC_A_IEN, 8'hFF);
         rd_chk(`TC_A_IEN, 8'hEF);
         wr_reg(`TC_A_IPR, 8'hFF);
         rd_chk(`TC_A_IPR, 8'h6F);
         chk({6'h00, irq_prio_b, irq_prio_a}, 8'h03);
         wr_reg(`TC_A_IPR, 8'h08);
         rd_chk(`TC_A_IPR, 8'h08);
         chk({6'h00, irq_prio_b, irq_prio_a}, 8'h02);
         wr_reg(8'h00, 8'hFF);
         rd_chk(8'h00, 8'h00);
         wr_reg(`TC_A_IEN, 8'h00);
      end
   endtask
   // Divided tick: 120 running edges give ten counts, none while stopped
   task t_div12;
      begin
         wr_reg(`TC_A_PRE, 8'h00);
         wr_reg(`TC_A_MODE, 8'h01);
         wr_reg(`TC_A_TLA, 8'h00);
         wr_reg(`TC_A_THA, 8'h00);
         wr_reg(`TC_A_CTRL, 8'h10);
         repeat (118) @(posedge core_clk);
         wr_reg(`TC_A_CTRL, 8'h00);
         rd_chk(`TC_A_TLA, 8'h0A);
         repeat (24) @(posedge core_clk);
         rd_chk(`TC_A_TLA, 8'h0A);
      end
   endtask
   // Pin counting: three falling edges on each pin
   task t_pins;
      begin
         wr_reg(`TC_A_MODE, 8'h55);
         wr_reg(`TC_A_TLA, 8'h00);
         wr_reg(`TC_A_TLB, 8'h00);
         wr_reg(`TC_A_CTRL, 8'h50);
         for (i = 0; i < 3; i = i + 1) begin
            go_a <= 1'b1;
            go_b <= 1'b1;
            @(posedge core_clk);
            go_a <= 1'b0;
            go_b <= 1'b0;
            repeat (16) @(posedge core_clk);
         end
         wr_reg(`TC_A_CTRL, 8'h00);
         rd_chk(`TC_A_TLA, 8'h03);
         rd_chk(`TC_A_TLB, 8'h03);
      end
   endtask
   // Interrupt raised, masked, unmasked, vectored and cleared
   task t_irq;
      begin
         wr_reg(`TC_A_STS, 8'h03);
         wr_reg(`TC_A_MSK, 8'h00);
         wr_reg(`TC_A_IEN, 8'h82);
         wr_reg(`TC_A_PRE, 8'h01);
         wr_reg(`TC_A_MODE, 8'h01);
         wr_reg(`TC_A_THA, 8'hFF);
         wr_reg(`TC_A_TLA, 8'hFF);
         one_step(8'h10);
         @(negedge core_clk);
         chk({6'h00, irq_req_b, irq_req_a}, 8'h01);
         chk({7'h00, irq}, 8'h00);
         @(posedge core_clk);
         wr_reg(`TC_A_MSK, 8'h01);
         @(negedge core_clk);
         chk({7'h00, irq}, 8'h01);
         @(posedge core_clk);
         vector_a <= 1'b1;
         @(posedge core_clk);
         vector_a <= 1'b0;
         @(posedge core_clk);
         @(negedge core_clk);
         chk({7'h00, irq_req_a}, 8'h00);
         chk({7'h00, irq}, 8'h01);
         @(posedge core_clk);
         rd_chk(`TC_A_STS, 8'h01);
         wr_reg(`TC_A_STS, 8'h01);
         @(negedge core_clk);
         chk({7'h00, irq}, 8'h00);
         @(posedge core_clk);
      end
   endtask
   // Timer B on the divided tick: 24 running edges give two counts,
   // one of them an overflow that drives request, status and mask of B
   task t_irq_b;
      begin
         wr_reg(`TC_A_STS, 8'h03);
         wr_reg(`TC_A_IEN, 8'h88);
         wr_reg(`TC_A_MSK, 8'h02);
         wr_reg(`TC_A_PRE, 8'h00);
         wr_reg(`TC_A_MODE, 8'h10);
         wr_reg(`TC_A_THB, 8'hFF);
         wr_reg(`TC_A_TLB, 8'hFF);
         wr_reg(`TC_A_CTRL, 8'h40);
         repeat (21) @(posedge core_clk);
         @(negedge core_clk);
         chk({6'h00, irq_req_b, irq_req_a}, 8'h02);
         chk({7'h00, irq}, 8'h01);
         @(posedge core_clk);
         wr_reg(`TC_A_CTRL, 8'h00);
         rd_chk(`TC_A_TLB, 8'h01);
         rd_chk(`TC_A_THB, 8'h00);
         rd_chk(`TC_A_STS, 8'h02);
         wr_reg(`TC_A_STS, 8'h02);
         @(negedge core_clk);
         chk({7'h00, irq}, 8'h00);
         @(posedge core_clk);
      end
   endtask
   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      t_regs;
      step_case(8'h01, 16'hFFFF, 16'h0000, 8'h10, 8'h20, 16'h0000, 16'h0000);
      step_case(8'h00, 16'h001F, 16'h0000, 8'h10, 8'h00, 16'h0100, 16'h0000);
      step_case(8'h00, 16'hFF1F, 16'h0000, 8'h10, 8'h20, 16'h0000, 16'h0000);
      step_case(8'h02, 16'h40FF, 16'h0000, 8'h10, 8'h20, 16'h4040, 16'h0000);
      step_case(8'h10, 16'h0000, 16'hFFFF, 8'h40, 8'h80, 16'h0000, 16'h0000);
      step_case(8'h00, 16'h0000, 16'h001F, 8'h40, 8'h00, 16'h0000, 16'h0100);
      step_case(8'h20, 16'h0000, 16'h7FFF, 8'h40, 8'h80, 16'h0000, 16'h7F7F);
      step_case(8'h30, 16'h0000, 16'h1234, 8'h40, 8'h00, 16'h0000, 16'h1234);
      step_case(8'h03, 16'hFF10, 16'h0005, 8'h50, 8'h80, 16'h0011, 16'h0005);
      step_case(8'h11, 16'h0005, 16'h0007, 8'h00, 8'h00, 16'h0005, 16'h0007);
      t_div12;
      t_pins;
      t_irq;
      t_irq_b;
      print_verdict;
   end
endmodule // test_dual_timer_counter_control
